// >>> core/omwc_defines.vh
// Constants for the operating mode and wake-up controller.
`ifndef OMWC_DEFINES_VH
`define OMWC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register map, byte addresses on the Avalon-MM word bus
// ----------------------------------------------------------------------------
`define OMWC_ADDR_W         4
`define OMWC_OFF_POWER_CONTROL_REG       4'h0
`define OMWC_OFF_CFG        4'h4
`define OMWC_OFF_STATUS     4'h8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OMWC_PC_IDLE        0
`define OMWC_PC_STOP        1
`define OMWC_PC_GF0         2
`define OMWC_CFG_XOSC       0
`define OMWC_CFG_WDT_ON     1

// ----------------------------------------------------------------------------
// Modes and warm-up counts
// ----------------------------------------------------------------------------
`define OMWC_MODE_NORMAL    2'h0
`define OMWC_MODE_IDLE      2'h1
`define OMWC_MODE_STOP      2'h2
`define OMWC_MODE_WARM      2'h3
`define OMWC_FAST_RC_CLKS   12'h040
`define OMWC_XOSC_CLKS      12'h800
`define OMWC_SLOW_CLKS      3'h5

`endif

// >>> core/omwc_top.v
// Operating mode and wake-up controller with Avalon-MM register access.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`include "omwc_defines.vh"

module omwc_top #(
  parameter P0_W   = 8,
  parameter IRQ_W  = 8
) (
  input  wire              CLK,
  input  wire              RST_N,
  input  wire              CE,
  input  wire [3:0]        AVS_ADDRESS,
  input  wire              AVS_READ,
  input  wire              AVS_WRITE,
  input  wire [31:0]       AVS_WRITEDATA,
  input  wire [3:0]        AVS_BYTEENABLE,
  output wire [31:0]       AVS_READDATA,
  output wire              AVS_WAITREQUEST,
  input  wire [P0_W-1:0]   PORT_ZERO_PINS,
  input  wire [IRQ_W-1:0]  IRQ_FLAGS,
  input  wire [IRQ_W-1:0]  IRQ_ENABLES,
  input  wire              GLOBAL_IRQ_ENABLE,
  input  wire              SLOW_CLK_TICK,
  output wire              CPU_CLK_EN,
  output wire              PERIPH_CLK_EN,
  output wire              IRQ_LOGIC_EN,
  output wire              FAST_RC_OSC_EN,
  output wire              SLOW_RC_OSC_EN,
  output wire              SYSCLK_FROM_FAST,
  output wire              REGULATOR_ON,
  output wire [1:0]        MODE
);

  // --------------------------------------------------------------------------
  // Mode encodings
  // --------------------------------------------------------------------------
  localparam [1:0] ST_NORMAL = `OMWC_MODE_NORMAL;
  localparam [1:0] ST_IDLE   = `OMWC_MODE_IDLE;
  localparam [1:0] ST_STOP   = `OMWC_MODE_STOP;
  localparam [1:0] ST_WARM   = `OMWC_MODE_WARM;

  // Mode decode used by the clock and power controls; the sequencer uses its own case.
  function mode_is;
    input [1:0] m;
    input [1:0] s;
    begin
      mode_is = (m == s);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  reg  [P0_W-1:0]   p0_s1_q;
  reg  [P0_W-1:0]   p0_s2_q;
  reg  [P0_W-1:0]   p0_prev_q;
  reg  [IRQ_W-1:0]  irq_s1_q;
  reg  [IRQ_W-1:0]  irq_s2_q;
  reg  [IRQ_W-1:0]  ien_s1_q;
  reg  [IRQ_W-1:0]  ien_s2_q;
  reg  [1:0]        gie_q;
  reg  [2:0]        slow_q;

  // Every pin and interrupt input passes two flip-flops before any logic
  // reads it, and all of them freeze while the clock enable is low.
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      p0_s1_q   <= {P0_W{1'b0}};
      p0_s2_q   <= {P0_W{1'b0}};
      p0_prev_q <= {P0_W{1'b0}};
      irq_s1_q  <= {IRQ_W{1'b0}};
      irq_s2_q  <= {IRQ_W{1'b0}};
      ien_s1_q  <= {IRQ_W{1'b0}};
      ien_s2_q  <= {IRQ_W{1'b0}};
      gie_q     <= 2'h0;
      slow_q    <= 3'h0;
    end
    else if (CE)
    begin
      p0_s1_q   <= PORT_ZERO_PINS;
      p0_s2_q   <= p0_s1_q;
      p0_prev_q <= p0_s2_q;
      irq_s1_q  <= IRQ_FLAGS;
      irq_s2_q  <= irq_s1_q;
      ien_s1_q  <= IRQ_ENABLES;
      ien_s2_q  <= ien_s1_q;
      gie_q     <= {gie_q[0], GLOBAL_IRQ_ENABLE};
      slow_q    <= {slow_q[1:0], SLOW_CLK_TICK};
    end
  end

  // --------------------------------------------------------------------------
  // Wake detection
  // --------------------------------------------------------------------------
  // Edges are armed only once the stage behind the synchroniser holds a real
  // pin level, so a pin that idles high gives no false wake after reset.
  reg  [2:0]        p0_arm_q;
  wire              p0_armed;
  wire [P0_W-1:0]   p0_edge;
  wire [IRQ_W-1:0]  irq_pend;
  wire              p0_change;
  wire              irq_wake;
  wire              slow_tick;
  genvar            gi;
  genvar            gj;

  generate
    for (gi = 0; gi < P0_W; gi = gi + 1)
    begin : g_p0_edge
      assign p0_edge[gi] = p0_s2_q[gi] ^ p0_prev_q[gi];
    end
  endgenerate

  generate
    for (gj = 0; gj < IRQ_W; gj = gj + 1)
    begin : g_irq_pend
      assign irq_pend[gj] = irq_s2_q[gj] & ien_s2_q[gj];
    end
  endgenerate

  assign p0_armed  = p0_arm_q[2];
  assign p0_change = p0_armed && (|p0_edge);
  assign irq_wake  = gie_q[1] && (|irq_pend);
  // Rising edges of the slow oscillator, read after its synchroniser.
  assign slow_tick = slow_q[1] && !slow_q[2];

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  reg  [1:0]        mode_q;
  reg               idle_bit_q;
  reg               stop_bit_q;
  reg               gf0_q;
  reg               xosc_q;
  reg               wdt_on_q;
  reg  [31:0]       rdata_q;
  reg               rvalid_q;
  reg               wake_irq_q;
  reg               wake_p0_q;
  wire              wr;
  wire              rd;
  wire [31:0]       rdata_d;

  // Offset match used by the read mux and both write decoders.
  function sel;
    input [3:0] a;
    input [3:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // A write lands only when the low byte lane is enabled.
  assign wr = AVS_WRITE && CE && AVS_BYTEENABLE[0];
  assign rd = AVS_READ && CE && !rvalid_q;
  // Reads take one cycle; writes are accepted at once while the clock enable
  // is high, and are held off while it is low so that none is lost.
  assign AVS_WAITREQUEST = (AVS_READ && !rvalid_q) || (AVS_WRITE && !CE);
  assign AVS_READDATA    = rdata_q;

  // Unmapped offsets read as zero.
  assign rdata_d = sel(AVS_ADDRESS, `OMWC_OFF_POWER_CONTROL_REG)   ? {29'h0, gf0_q, stop_bit_q, idle_bit_q} :
                   sel(AVS_ADDRESS, `OMWC_OFF_CFG)    ? {30'h0, wdt_on_q, xosc_q} :
                   sel(AVS_ADDRESS, `OMWC_OFF_STATUS) ? {28'h0, wake_p0_q, wake_irq_q, mode_q} :
                   32'h0;

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rdata_q  <= 32'h0;
      rvalid_q <= 1'b0;
    end
    else if (CE)
    begin
      rvalid_q <= rd;
      if (rd)
        rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Mode sequencer
  // --------------------------------------------------------------------------
  reg  [11:0]       fast_cnt_q;
  reg  [2:0]        slow_cnt_q;
  wire              pc_wr;
  wire              req_idle;
  wire              req_stop;
  wire [11:0]       warm_clks;
  wire              fast_done;
  wire              slow_done;

  assign pc_wr     = wr && sel(AVS_ADDRESS, `OMWC_OFF_POWER_CONTROL_REG);
  assign req_stop  = pc_wr && AVS_WRITEDATA[`OMWC_PC_STOP];
  assign req_idle  = pc_wr && AVS_WRITEDATA[`OMWC_PC_IDLE];
  assign warm_clks = xosc_q ? `OMWC_XOSC_CLKS : `OMWC_FAST_RC_CLKS;
  // Warm-up ends only when the fast count and then the slow ticks are both in.
  assign fast_done = (fast_cnt_q == warm_clks);
  assign slow_done = (slow_cnt_q == `OMWC_SLOW_CLKS);

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_q     <= `OMWC_MODE_NORMAL;
      idle_bit_q <= 1'b0;
      stop_bit_q <= 1'b0;
      gf0_q      <= 1'b0;
      xosc_q     <= 1'b0;
      wdt_on_q   <= 1'b0;
      fast_cnt_q <= 12'h0;
      slow_cnt_q <= 3'h0;
      wake_irq_q <= 1'b0;
      wake_p0_q  <= 1'b0;
      p0_arm_q   <= 3'h0;
    end
    else if (CE)
    begin
      p0_arm_q <= {p0_arm_q[1:0], 1'b1};
      if (wr && sel(AVS_ADDRESS, `OMWC_OFF_CFG))
      begin
        xosc_q   <= AVS_WRITEDATA[`OMWC_CFG_XOSC];
        wdt_on_q <= AVS_WRITEDATA[`OMWC_CFG_WDT_ON];
      end
      if (pc_wr)
        gf0_q <= AVS_WRITEDATA[`OMWC_PC_GF0];
      case (mode_q)
        ST_NORMAL:
        begin
          if (p0_change || irq_wake)
          begin
            // Wake wins over a request made in the same cycle.
            idle_bit_q <= 1'b0;
            stop_bit_q <= 1'b0;
            wake_p0_q  <= p0_change;
            wake_irq_q <= irq_wake && !p0_change;
          end
          // A stop request wins when both request bits are written as one.
          else if (req_stop)
          begin
            stop_bit_q <= 1'b1;
            mode_q     <= `OMWC_MODE_STOP;
          end
          else if (req_idle)
          begin
            idle_bit_q <= 1'b1;
            mode_q     <= `OMWC_MODE_IDLE;
          end
        end
        ST_IDLE:
        begin
          // The idle request bit is cleared on wake so the CPU resumes in normal mode.
          if (p0_change || irq_wake)
          begin
            idle_bit_q <= 1'b0;
            mode_q     <= `OMWC_MODE_NORMAL;
            wake_p0_q  <= p0_change;
            wake_irq_q <= irq_wake && !p0_change;
          end
        end
        ST_STOP:
        begin
          // Interrupt logic is off here, so only a pin change restarts the clocks.
          if (p0_change)
          begin
            fast_cnt_q <= 12'h0;
            slow_cnt_q <= 3'h0;
            wake_p0_q  <= 1'b1;
            wake_irq_q <= 1'b0;
            mode_q     <= `OMWC_MODE_WARM;
          end
        end
        ST_WARM:
        begin
          // Fast clocks are counted first, then slow oscillator ticks.
          if (!fast_done)
            fast_cnt_q <= fast_cnt_q + 12'h1;
          else if (!slow_done)
          begin
            if (slow_tick)
              slow_cnt_q <= slow_cnt_q + 3'h1;
          end
          else
          begin
            stop_bit_q <= 1'b0;
            mode_q     <= `OMWC_MODE_NORMAL;
          end
        end
        default:
          mode_q <= `OMWC_MODE_NORMAL;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Clock and power controls
  // --------------------------------------------------------------------------
  wire in_normal;
  wire in_stop;
  wire in_warm;

  assign in_normal        = mode_is(mode_q, ST_NORMAL);
  assign in_stop          = mode_is(mode_q, ST_STOP);
  assign in_warm          = mode_is(mode_q, ST_WARM);
  assign CPU_CLK_EN       = in_normal;
  // Peripherals stay gated until the oscillators have finished warming up.
  assign PERIPH_CLK_EN    = !in_stop && !in_warm;
  assign IRQ_LOGIC_EN     = PERIPH_CLK_EN;
  assign FAST_RC_OSC_EN   = !in_stop;
  // The slow oscillator keeps running in stop only for an always-on watchdog.
  assign SLOW_RC_OSC_EN   = !in_stop || wdt_on_q;
  // Only the fast oscillator can clock the system in this block.
  assign SYSCLK_FROM_FAST = 1'b1;
  assign REGULATOR_ON     = 1'b1;
  assign MODE             = mode_q;

endmodule

// >>> verif/omwc_asserts.sv
// Concurrent checks on the mode controller ports.
`timescale 1ns/1ns
module omwc_asserts #(
  parameter P0_W  = 8,
  parameter IRQ_W = 8
) (
  input wire             CLK,
  input wire             RST_N,
  input wire             CE,
  input wire             AVS_READ,
  input wire             AVS_WAITREQUEST,
  input wire [P0_W-1:0]  PORT_ZERO_PINS,
  input wire [IRQ_W-1:0] IRQ_FLAGS,
  input wire [IRQ_W-1:0] IRQ_ENABLES,
  input wire             GLOBAL_IRQ_ENABLE,
  input wire             CPU_CLK_EN,
  input wire             PERIPH_CLK_EN,
  input wire             IRQ_LOGIC_EN,
  input wire             FAST_RC_OSC_EN,
  input wire             SLOW_RC_OSC_EN,
  input wire             SYSCLK_FROM_FAST,
  input wire             REGULATOR_ON,
  input wire [1:0]       MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence stop_to_warm_s;
    MODE == 2'h2 ##1 MODE == 2'h3;
  endsequence
  cpu_gate_a: assert property (CPU_CLK_EN == (MODE == 2'h0)) else $error("cpu clock enable wrong");
  normal_osc_a: assert property (MODE == 2'h0 |-> FAST_RC_OSC_EN && SLOW_RC_OSC_EN && SYSCLK_FROM_FAST)
    else $error("normal mode clocks wrong");
  stop_off_a: assert property (MODE == 2'h2 |-> !FAST_RC_OSC_EN && !PERIPH_CLK_EN && !IRQ_LOGIC_EN)
    else $error("stop mode left something running");
  idle_run_a: assert property (MODE == 2'h1 |-> FAST_RC_OSC_EN && PERIPH_CLK_EN && IRQ_LOGIC_EN)
    else $error("idle mode stopped peripherals");
  regulator_a: assert property (REGULATOR_ON) else $error("regulator off");
  stop_exit_a: assert property (MODE == 2'h2 |=> MODE == 2'h2 || MODE == 2'h3)
    else $error("stop left without warm-up");
  stop_hold_a: assert property ((MODE == 2'h2 && $stable(PORT_ZERO_PINS)) [*5] |=> MODE == 2'h2)
    else $error("stop woke without pin change");
  warm_hold_a: assert property (stop_to_warm_s |-> ##60 MODE == 2'h3)
    else $error("warm-up too short");
  idle_wake_a: assert property ((MODE == 2'h1 && GLOBAL_IRQ_ENABLE && CE && |(IRQ_FLAGS & IRQ_ENABLES))
    |-> ##[0:6] MODE == 2'h0) else $error("enabled interrupt did not wake idle");
  read_wait_a: assert property (AVS_READ && AVS_WAITREQUEST && CE |=> !AVS_WAITREQUEST)
    else $error("read answer late");
endmodule
bind omwc_top omwc_asserts #(.P0_W(P0_W), .IRQ_W(IRQ_W)) u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE),
  .AVS_READ(AVS_READ), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PORT_ZERO_PINS(PORT_ZERO_PINS),
  .IRQ_FLAGS(IRQ_FLAGS), .IRQ_ENABLES(IRQ_ENABLES), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .IRQ_LOGIC_EN(IRQ_LOGIC_EN),
  .FAST_RC_OSC_EN(FAST_RC_OSC_EN), .SLOW_RC_OSC_EN(SLOW_RC_OSC_EN),
  .SYSCLK_FROM_FAST(SYSCLK_FROM_FAST), .REGULATOR_ON(REGULATOR_ON), .MODE(MODE));

// >>> verif/omwc_slow_osc.sv
// Slow oscillator model that only runs while enabled.
`timescale 1ns/1ns
module omwc_slow_osc (
  input wire clk,
  input wire rst_n,
  input wire en,
  output reg tick
);
  reg [1:0] div_q;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      div_q <= 2'h0;
      tick  <= 1'b0;
    end
    else if (en)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3)
        tick <= ~tick;
    end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the mode controller.
`timescale 1ns/1ns
module tb;
  reg CLK, RST_N, rd_q, wr_q, gie, wq_s;
  reg [3:0] adr, be;
  reg [31:0] wdat, d, rd_s;
  reg [7:0] p0, irqf, irqe;
  wire [31:0] rdat;
  wire wreq, tick, cpu, per, fast, slow;
  wire [1:0] MODE;
  int fails, compares, n;
  omwc_top uut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .AVS_ADDRESS(adr), .AVS_READ(rd_q),
    .AVS_WRITE(wr_q), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .PORT_ZERO_PINS(p0), .IRQ_FLAGS(irqf), .IRQ_ENABLES(irqe),
    .GLOBAL_IRQ_ENABLE(gie), .SLOW_CLK_TICK(tick), .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(per),
    .IRQ_LOGIC_EN(), .FAST_RC_OSC_EN(fast), .SLOW_RC_OSC_EN(slow), .SYSCLK_FROM_FAST(),
    .REGULATOR_ON(), .MODE(MODE));
  omwc_slow_osc u_osc (.clk(CLK), .rst_n(RST_N), .en(slow), .tick(tick));
  always #50 CLK = ~CLK;
  always @(negedge CLK)
  begin
    wq_s = wreq;
    rd_s = rdat;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [3:0] a, input [31:0] v, input [3:0] b);
    @(posedge CLK);
    adr <= a; wdat <= v; be <= b; wr_q <= 1'b1;
    @(posedge CLK);
    while (wq_s) @(posedge CLK);
    wr_q <= 1'b0;
  endtask
  task rd(input [3:0] a, output [31:0] v);
    @(posedge CLK);
    adr <= a; rd_q <= 1'b1;
    @(posedge CLK);
    while (wq_s) @(posedge CLK);
    v = rd_s;
    rd_q <= 1'b0;
  endtask
  task wm(input [1:0] m);
    n = 0;
    while (MODE !== m && n < 3000)
    begin
      @(negedge CLK);
      n++;
    end
    chk("mode", m, MODE);
  endtask
  task finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    finish_test;
  end
  initial
  begin
    CLK = 0; RST_N = 0; rd_q = 0; wr_q = 0; gie = 0; adr = 0; be = 0; wdat = 0;
    p0 = 0; irqf = 0; irqe = 0; fails = 0; compares = 0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (5) @(negedge CLK);
    chk("mode", 0, MODE);
    chk("cpu", 1, cpu);
    rd(4'h0, d); chk("power_control_reg", 0, d);
    wr(4'h0, 1, 4'hf); wm(1);
    chk("cpu", 0, cpu);
    chk("periph", 1, per);
    rd(4'h0, d); chk("power_control_reg", 1, d);
    @(posedge CLK) {irqf, irqe} <= 16'h0404;
    repeat (10) @(negedge CLK);
    chk("mode", 1, MODE);
    @(posedge CLK) gie <= 1'b1;
    wm(0);
    rd(4'h8, d); chk("status", 32'h4, d);
    wr(4'h0, 1, 4'hf);
    repeat (6) @(negedge CLK);
    chk("mode", 0, MODE);
    @(posedge CLK) {irqf, irqe} <= 16'h0;
    rd(4'h0, d); chk("power_control_reg", 0, d);
    wr(4'h0, 2, 4'hf); wm(2);
    chk("fast osc", 0, fast);
    chk("slow osc", 0, slow);
    repeat (20) @(negedge CLK);
    chk("mode", 2, MODE);
    @(posedge CLK) p0 <= 8'h08;
    wm(3);
    n = 0;
    while (MODE === 2'h3 && n < 3000)
    begin
      @(negedge CLK);
      n++;
    end
    chk("warm", 1, n >= 65);
    chk("mode", 0, MODE);
    rd(4'h0, d); chk("power_control_reg", 0, d);
    @(posedge CLK) gie <= 1'b0;
    wr(4'h0, 1, 4'hf); wm(1);
    @(posedge CLK) p0 <= 8'h00;
    wm(0);
    wr(4'h0, 3, 4'hf); wm(2);
    @(posedge CLK) p0 <= 8'h80;
    wm(0);
    wr(4'h4, 3, 4'hf); wr(4'h0, 2, 4'hf); wm(2);
    chk("slow osc", 1, slow);
    @(posedge CLK) p0 <= 8'h00;
    wm(3);
    n = 0;
    while (MODE === 2'h3 && n < 3000)
    begin
      @(negedge CLK);
      n++;
    end
    chk("warm ext", 1, n >= 2049);
    chk("mode", 0, MODE);
    wr(4'h0, 2, 4'he);
    repeat (6) @(negedge CLK);
    chk("mode", 0, MODE);
    rd(4'hc, d); chk("unmapped", 0, d);
    finish_test;
  end
endmodule
